/* File: rtl/dss_sequencer.sv */
// Start/stop sequencer with velocity_command ramps and an APB register port.
// Assumes pins arrive asynchronously; APB runs on mclk_i.
// Notes on behaviour
// R1: Remote run ramps to reference, holds there
// R2: Jog ramps to inch target while held
// R3: Run key latches; stop key stops
// R4: Jog key acts only while held
// R5: Run or jog exclusive; change after stop
// R6: In-motion from start until stage quenched
// R7: No-fault flag false only while tripped
// R8: Reset: ramp stop, 10 s halt ramp
// R9: Ramped stop: fall ramp, then offset ramp
// R10: Without offset, fall ramp reaches zero
// R11: Stage held energised for hold interval
// R12: Zero fall time or freeze: halt rate
// R13: Freewheel: zero demand, stage off at once
// R14: Quick halt stops by its own method
// R15: Freewheel halt wins, disables stage immediately
// R16: Trip coasts; restart needs clear and reset
// R17: Halt_n low over 100 ms stops; the code only clears the three-wire latches, so other modes ignore halt_n
// R18: Two-wire run and reverse together stop
// R19: Three-wire latches only while halt_n high
// R20: Jog is never latched
// R21: Power permit low forces stage off
// R22: Sequencing and reference chosen independently
// R23: Ramps step linearly, one LSB per step
`timescale 1ns/1ps
`default_nettype none

module dss_sequencer
  import dss_pkg::*;
#(
  parameter int unsigned HALT_MIN_CYC = HALT_N_MIN_CYC  // Shorten for simulation
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire dss_pins_t pins_i,
  output logic [15:0] velocity_command_o,
  output logic [15:0] velocity_offset_o,
  output logic direction_request_out_o,
  output logic power_stage_en_o,
  output logic in_motion_flag_o,
  output logic no_fault_flag_o
);

  // ***************************************************************
  // Pin synchronisers
  // ***************************************************************
  logic [PIN_W-1:0] s1_ff; // First stage, read only by second
  logic [PIN_W-1:0] s2_ff; // Safe to use
  dss_pins_t pin;

  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++)
    begin : g_sync
      // Two flops per pin
      always_ff @(posedge mclk_i)
      begin
        if (!rstn_i)
        begin
          s1_ff[gi] <= PIN_RST[gi];
          s2_ff[gi] <= PIN_RST[gi];
        end
        else
        begin
          s1_ff[gi] <= pins_i[gi];
          s2_ff[gi] <= s1_ff[gi];
        end
      end
    end
  endgenerate
  assign pin = dss_pins_t'(s2_ff);

  // ***************************************************************
  // Registers and APB slave
  // ***************************************************************
  logic [15:0] ctrl_ff;
  logic [15:0] ref_ff, kptgt_ff, inch_ff, ofsp_ff;
  logic [31:0] rise_ff, fall_ff, irise_ff, halt_ff, shold_ff;
  logic [31:0] rdata_ff;
  logic rdy_ff, err_ff;
  dss_state_t state_ff, nxt_state;
  logic [15:0] vel_ff, off_ff;
  logic dir_ff, pwr_ff, motion_ff, nofault_ff;

  wire apb_setup = psel_i & ~penable_i;                 // Decode in setup
  wire apb_wr = psel_i & penable_i & pready_o & pwrite_i; // Write commit edge
  wire addr_ok = (paddr_i <= OFS_VEL) && (paddr_i[1:0] == 2'h0);
  wire ro_hit = (paddr_i == OFS_STATUS) || (paddr_i == OFS_VEL);
  wire trip_rst = apb_wr && (paddr_i == OFS_CTRL) && pwdata_i[CB_TRIP_RST];
  logic [31:0] rd_mux;

  // Read data selection
  always_comb
  begin
    case (paddr_i)
      OFS_CTRL: rd_mux = {16'h0000, ctrl_ff};
      OFS_REF: rd_mux = {16'h0000, ref_ff};
      OFS_KPTGT: rd_mux = {16'h0000, kptgt_ff};
      OFS_INCH: rd_mux = {16'h0000, inch_ff};
      OFS_RISE: rd_mux = rise_ff;
      OFS_FALL: rd_mux = fall_ff;
      OFS_IRISE: rd_mux = irise_ff;
      OFS_HALT: rd_mux = halt_ff;
      OFS_SHOLD: rd_mux = shold_ff;
      OFS_OFFSET: rd_mux = {16'h0000, ofsp_ff};
      OFS_STATUS: rd_mux = {24'h000000, nofault_ff, motion_ff, pwr_ff, dir_ff,
                            1'b0, state_ff};
      OFS_VEL: rd_mux = {off_ff, vel_ff};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Answer one cycle after setup: pready high in first access cycle
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      rdy_ff <= 1'b0;
      err_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
    end
    else
    begin
      rdy_ff <= apb_setup;
      err_ff <= apb_setup & ~addr_ok;
      rdata_ff <= apb_setup ? rd_mux : rdata_ff;
    end
  end

  // Register writes; trip reset bit does not stick
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      ctrl_ff <= CTRL_RST; // [R8]
      ref_ff <= 16'h0000;
      kptgt_ff <= 16'h0000;
      inch_ff <= 16'h0000;
      ofsp_ff <= 16'h0000;
      rise_ff <= 32'h00000000;
      fall_ff <= 32'h00000000;
      irise_ff <= 32'h00000000;
      halt_ff <= HALT_DEF_STEP; // [R8]
      shold_ff <= 32'h00000000;
    end
    else if (apb_wr && addr_ok && !ro_hit)
    begin
      case (paddr_i)
        OFS_CTRL: ctrl_ff <= pwdata_i[15:0] & ~(16'h0001 << CB_TRIP_RST);
        OFS_REF: ref_ff <= pwdata_i[15:0];
        OFS_KPTGT: kptgt_ff <= pwdata_i[15:0];
        OFS_INCH: inch_ff <= pwdata_i[15:0];
        OFS_RISE: rise_ff <= pwdata_i;
        OFS_FALL: fall_ff <= pwdata_i;
        OFS_IRISE: irise_ff <= pwdata_i;
        OFS_HALT: halt_ff <= pwdata_i;
        OFS_SHOLD: shold_ff <= pwdata_i;
        OFS_OFFSET: ofsp_ff <= pwdata_i[15:0];
        default: ctrl_ff <= ctrl_ff;
      endcase
    end
  end

  // ***************************************************************
  // Command decoding
  // ***************************************************************
  wire seq_rem = ctrl_ff[CB_SEQ_REM];   // [R22]
  wire ref_rem = ctrl_ff[CB_REF_REM];   // [R22]
  wire [1:0] wire_mode = ctrl_ff[CB_WIRE_LO +: 2];
  wire force_coast = ~pin.freewheel_halt_n | ~pin.power_stage_enable; // [R15] [R21]
  wire quick = ~pin.quick_halt_n & ~force_coast; // [R14] [R15]
  logic [HCNT_W-1:0] hcnt_ff;
  logic halt_req;
  logic latf_ff, latb_ff, kprun_ff;
  // Three-wire latches live only in remote three-wire mode, so a mode change cannot start a run from a stale one; kprun_ff is kept in all modes
  wire three_w = seq_rem && (wire_mode == WIRE_THREE); // [R19]

  // Halt_n must stay low past the least time to count as a stop
  assign halt_req = ~pin.halt_n && (hcnt_ff == HCNT_W'(HALT_MIN_CYC - 1)); // [R17]

  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
      hcnt_ff <= '0;
    else if (pin.halt_n)
      hcnt_ff <= '0;
    else if (!halt_req)
      hcnt_ff <= hcnt_ff + 1'b1;
  end

  // Three-wire and keypad start latches; jog is never latched [R20]
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      latf_ff <= 1'b0;
      latb_ff <= 1'b0;
      kprun_ff <= 1'b0;
    end
    else
    begin
      if (halt_req || force_coast || quick || pin.trip || !three_w)
      begin
        latf_ff <= 1'b0;
        latb_ff <= 1'b0;
      end
      else if (pin.halt_n && pin.run && !pin.reverse) // [R19]
      begin
        latf_ff <= 1'b1;
        latb_ff <= 1'b0;
      end
      else if (pin.halt_n && pin.reverse && !pin.run) // [R19]
      begin
        latf_ff <= 1'b0;
        latb_ff <= 1'b1;
      end
      // Stop key wins over run key; forced stops drop the latch too
      if (pin.key_stop || force_coast || quick || pin.trip)
        kprun_ff <= 1'b0;
      else if (pin.key_run)
        kprun_ff <= 1'b1; // [R3]
    end
  end

  logic fwd_req, bwd_req;
  // Remote start request per wire mode
  always_comb
  begin
    case (wire_mode)
      WIRE_ONE:
      begin
        fwd_req = pin.run;
        bwd_req = 1'b0;
      end
      WIRE_TWO:
      begin
        fwd_req = pin.run & ~pin.reverse; // [R18]
        bwd_req = pin.reverse & ~pin.run; // [R18]
      end
      WIRE_THREE:
      begin
        fwd_req = latf_ff;
        bwd_req = latb_ff;
      end
      default:
      begin
        fwd_req = 1'b0;
        bwd_req = 1'b0;
      end
    endcase
  end

  wire run_cmd = seq_rem ? (fwd_req | bwd_req) : kprun_ff;
  wire run_dir = seq_rem ? bwd_req : pin.key_dir;
  wire jog_cmd = seq_rem ? pin.jog : pin.key_jog; // [R4]
  wire [15:0] run_tgt = ref_rem ? ref_ff : kptgt_ff;

  // ***************************************************************
  // Sequencer state machine
  // ***************************************************************
  wire stop_run = quick | ~run_cmd;
  wire stop_jog = quick | ~jog_cmd;
  wire stop_fw = quick ? ctrl_ff[CB_QUICK_FW] : ctrl_ff[CB_NORM_FW]; // [R14]
  logic [31:0] hold_ff;
  logic [31:0] pre_ff;

  always_comb
  begin
    nxt_state = state_ff;
    if (pin.trip)
      nxt_state = S_TRIP; // [R16]
    else if (force_coast && state_ff != S_TRIP)
      nxt_state = S_IDLE; // [R15] [R21]
    else
    begin
      case (state_ff)
        S_IDLE:
          if (quick)
            nxt_state = S_IDLE;
          else if (run_cmd)
            nxt_state = S_RUN; // [R1] [R3] [R5]
          else if (jog_cmd)
            nxt_state = S_JOG; // [R2] [R5]
        S_RUN:
          if (stop_run)
            nxt_state = stop_fw ? S_IDLE : S_FALL; // [R13]
        S_JOG:
          if (stop_jog)
            nxt_state = stop_fw ? S_IDLE : S_FALL; // [R4] [R13]
        S_FALL:
          if (vel_ff == 16'h0000)
            nxt_state = ctrl_ff[CB_OFS_EN] ? S_TRIM : S_HOLD; // [R9] [R10]
        S_TRIM:
          if (off_ff == 16'h0000)
            nxt_state = S_HOLD; // [R9]
        S_HOLD:
          if (hold_ff >= shold_ff)
            nxt_state = S_IDLE; // [R11]
        S_TRIP:
          if (trip_rst)
            nxt_state = S_IDLE; // [R16]
        default: nxt_state = S_IDLE;
      endcase
    end
  end

  // ***************************************************************
  // Ramp engine
  // ***************************************************************
  logic [15:0] tgt;
  logic [31:0] dur;
  wire fall_slow = (fall_ff == 32'h00000000) | ctrl_ff[CB_FREEZE]; // [R12]

  // Target and step period per state
  always_comb
  begin
    case (state_ff)
      S_RUN:
      begin
        tgt = run_tgt; // [R1]
        dur = rise_ff;
      end
      S_JOG:
      begin
        tgt = inch_ff; // [R2]
        dur = irise_ff;
      end
      S_FALL:
      begin
        tgt = 16'h0000;
        dur = fall_slow ? halt_ff : fall_ff; // [R10] [R12]
      end
      default:
      begin
        tgt = 16'h0000;
        dur = halt_ff; // [R9]
      end
    endcase
  end

  // One LSB per step, one step every dur cycles (at least one)
  wire step = (pre_ff + 32'h00000001 >= dur); // [R23]
  wire moving = (nxt_state == state_ff);
  wire live = (nxt_state != S_IDLE) && (nxt_state != S_TRIP);

  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
      pre_ff <= 32'h00000000;
    else if (!moving || step)
      pre_ff <= 32'h00000000;
    else
      pre_ff <= pre_ff + 32'h00000001;
  end

  // State, velocity, offset and hold counter
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      state_ff <= S_IDLE;
      vel_ff <= 16'h0000;
      off_ff <= 16'h0000;
      hold_ff <= 32'h00000000;
      dir_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      hold_ff <= (state_ff == S_HOLD) ? hold_ff + 32'h00000001 : 32'h00000000;
      if (!live)
        vel_ff <= 16'h0000; // [R13] [R16]
      else if (step && state_ff != S_TRIM && state_ff != S_HOLD)
      begin
        if (vel_ff < tgt)
          vel_ff <= vel_ff + 16'h0001; // [R23]
        else if (vel_ff > tgt)
          vel_ff <= vel_ff - 16'h0001; // [R23]
      end
      // Offset tracks its preset until a ramped stop trims it
      if (state_ff == S_TRIM && step && off_ff != 16'h0000)
        off_ff <= off_ff - 16'h0001; // [R9]
      else if (state_ff == S_HOLD || state_ff == S_TRIM)
        off_ff <= off_ff;
      else
        off_ff <= ctrl_ff[CB_OFS_EN] ? ofsp_ff : 16'h0000;
      // Direction taken only at start; a reversal needs a stop first
      if (state_ff == S_IDLE && nxt_state != S_IDLE)
        dir_ff <= run_cmd ? run_dir : (seq_rem ? pin.reverse : pin.key_dir);
    end
  end

  // Status outputs, all registered
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      pwr_ff <= 1'b0;
      motion_ff <= 1'b0;
      nofault_ff <= 1'b1;
    end
    else
    begin
      pwr_ff <= live & pin.power_stage_enable & ~force_coast; // [R11] [R21]
      motion_ff <= live; // [R6]
      nofault_ff <= (nxt_state != S_TRIP); // [R7]
    end
  end

  assign prdata_o = rdata_ff;
  assign pready_o = rdy_ff;
  assign pslverr_o = err_ff;
  assign velocity_command_o = vel_ff;
  assign velocity_offset_o = off_ff;
  assign direction_request_out_o = dir_ff;
  assign power_stage_en_o = pwr_ff;
  assign in_motion_flag_o = motion_ff;
  assign no_fault_flag_o = nofault_ff;

  // ***************************************************************
  // Assertions
  // ***************************************************************
  property p_coast_wins;
    @(posedge mclk_i) disable iff (!rstn_i) !pin.freewheel_halt_n |=> !power_stage_en_o;
  endproperty
  a_coast_wins: assert property (p_coast_wins) else $error("stage on in coast"); // [R15]

  property p_permit;
    @(posedge mclk_i) disable iff (!rstn_i) !pin.power_stage_enable |=> !power_stage_en_o;
  endproperty
  a_permit: assert property (p_permit) else $error("stage on without permit"); // [R21]

  property p_trip;
    @(posedge mclk_i) disable iff (!rstn_i)
      pin.trip |=> !no_fault_flag_o && !power_stage_en_o && velocity_command_o == 16'h0000;
  endproperty
  a_trip: assert property (p_trip) else $error("trip not honoured"); // [R16] [R7]

  property p_motion;
    @(posedge mclk_i) disable iff (!rstn_i) power_stage_en_o |-> in_motion_flag_o;
  endproperty
  a_motion: assert property (p_motion) else $error("stage on while not in motion"); // [R6]

  property p_two_wire;
    @(posedge mclk_i) disable iff (!rstn_i)
      seq_rem && wire_mode == WIRE_TWO && pin.run && pin.reverse && state_ff == S_RUN
      |=> state_ff != S_RUN;
  endproperty
  a_two_wire: assert property (p_two_wire) else $error("both inputs kept run"); // [R18]

  property p_jog_held;
    @(posedge mclk_i) disable iff (!rstn_i) state_ff == S_JOG && !jog_cmd |=> state_ff != S_JOG;
  endproperty
  a_jog_held: assert property (p_jog_held) else $error("jog continued"); // [R20]

  property p_exclusive;
    @(posedge mclk_i) disable iff (!rstn_i) state_ff == S_RUN |=> state_ff != S_JOG;
  endproperty
  a_exclusive: assert property (p_exclusive) else $error("run went to jog"); // [R5]

  property p_freewheel;
    @(posedge mclk_i) disable iff (!rstn_i)
      state_ff == S_RUN && nxt_state == S_IDLE |=> velocity_command_o == 16'h0000
      && !power_stage_en_o;
  endproperty
  a_freewheel: assert property (p_freewheel) else $error("freewheel not immediate"); // [R13]

  property p_hold_energised;
    @(posedge mclk_i) disable iff (!rstn_i)
      state_ff == S_HOLD && pin.power_stage_enable && !force_coast && !pin.trip
      |-> power_stage_en_o;
  endproperty
  a_hold_energised: assert property (p_hold_energised) else $error("stage off in hold"); // [R11]

  property p_linear;
    @(posedge mclk_i) disable iff (!rstn_i)
      state_ff == S_RUN && $past(state_ff) == S_RUN
      |-> (velocity_command_o - $past(velocity_command_o) + 16'h0001) <= 16'h0002;
  endproperty
  a_linear: assert property (p_linear) else $error("ramp jumped"); // [R23]

  c_run: cover property (@(posedge mclk_i) disable iff (!rstn_i) state_ff == S_RUN);
  c_trim: cover property (@(posedge mclk_i) disable iff (!rstn_i) state_ff == S_TRIM);
  c_trip_clr: cover property (@(posedge mclk_i) disable iff (!rstn_i)
    state_ff == S_TRIP ##1 state_ff == S_IDLE);

endmodule // dss_sequencer

`default_nettype wire

/* File: rtl/dss_pkg.sv */
// Shared constants and types for the drive start/stop sequencer.
// Assumes a single 125 MHz clock and an APB register port with 32-bit data.
package dss_pkg;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int unsigned CLK_MHZ = 125;              // System clock rate
  localparam int unsigned CYC_PER_MS = CLK_MHZ * 1000; // Cycles in one millisecond
  localparam int unsigned HALT_N_MIN_MS = 100;        // Least low time of halt_n
  localparam int unsigned HALT_N_MIN_CYC = HALT_N_MIN_MS * CYC_PER_MS;
  localparam int unsigned HALT_DEF_MS = 10000;        // Default halt ramp, 10.0 s
  localparam int unsigned VEL_FULL = 65535;           // Full-scale velocity steps
  // Cycles per one-LSB step so full scale takes the halt time
  localparam longint unsigned HALT_DEF_PROD = longint'(HALT_DEF_MS) * CYC_PER_MS;
  localparam logic [31:0] HALT_DEF_STEP = 32'(HALT_DEF_PROD / VEL_FULL);
  localparam int unsigned HCNT_W = 24;                // Width of halt_n filter counter

  // ***************************************************************
  // Register map (byte addresses)
  // ***************************************************************
  localparam int unsigned AW = 8;
  localparam logic [AW-1:0] OFS_CTRL = 8'h00;      // Mode and selection bits
  localparam logic [AW-1:0] OFS_REF = 8'h04;       // Remote reference
  localparam logic [AW-1:0] OFS_KPTGT = 8'h08;     // keypad_target
  localparam logic [AW-1:0] OFS_INCH = 8'h0c;      // inch_target
  localparam logic [AW-1:0] OFS_RISE = 8'h10;      // rise_ramp_duration
  localparam logic [AW-1:0] OFS_FALL = 8'h14;      // fall_ramp_duration
  localparam logic [AW-1:0] OFS_IRISE = 8'h18;     // inch_rise_duration
  localparam logic [AW-1:0] OFS_HALT = 8'h1c;      // halt_ramp_duration
  localparam logic [AW-1:0] OFS_SHOLD = 8'h20;     // stack_hold_interval
  localparam logic [AW-1:0] OFS_OFFSET = 8'h24;    // velocity_offset preset
  localparam logic [AW-1:0] OFS_STATUS = 8'h28;    // Read-only state
  localparam logic [AW-1:0] OFS_VEL = 8'h2c;       // Read-only velocities

  // CTRL fields
  localparam int unsigned CB_SEQ_REM = 0;    // Start/stop from terminals
  localparam int unsigned CB_REF_REM = 1;    // Reference from register
  localparam int unsigned CB_NORM_FW = 2;    // normal_halt_select: 1 freewheel
  localparam int unsigned CB_QUICK_FW = 3;   // quick_halt_select: 1 freewheel
  localparam int unsigned CB_FREEZE = 4;     // freeze_ramp
  localparam int unsigned CB_TRIP_RST = 5;   // Write 1: trip reset pulse
  localparam int unsigned CB_WIRE_LO = 6;    // Wire mode, 2 bits
  localparam int unsigned CB_OFS_EN = 8;     // velocity_offset in use
  localparam logic [15:0] CTRL_RST = 16'h0003;  // Remote both, ramp stop

  localparam logic [1:0] WIRE_ONE = 2'h0;
  localparam logic [1:0] WIRE_TWO = 2'h1;
  localparam logic [1:0] WIRE_THREE = 2'h2;

  // ***************************************************************
  // Types
  // ***************************************************************
  typedef enum logic [2:0] {S_IDLE, S_RUN, S_JOG, S_FALL, S_TRIM, S_HOLD, S_TRIP} dss_state_t;

  typedef struct packed {
    logic run;                // Remote run / go_forward
    logic reverse;            // Remote reverse / go_backward
    logic jog;                // Remote jog
    logic halt_n;             // Stop request, active low
    logic quick_halt_n;       // Forced fast stop, active low
    logic freewheel_halt_n;   // Forced coast stop, active low
    logic power_stage_enable; // Power stage permit
    logic trip;               // Trip condition present
    logic key_run;
    logic key_stop;
    logic key_jog;
    logic key_dir;            // Keypad direction, 1 reverse
  } dss_pins_t;

  localparam int unsigned PIN_W = $bits(dss_pins_t);
  // Stop inputs idle high so reset does not look like a stop
  localparam dss_pins_t PIN_RST = '{run: 1'b0, reverse: 1'b0, jog: 1'b0, halt_n: 1'b1,
    quick_halt_n: 1'b1, freewheel_halt_n: 1'b1, power_stage_enable: 1'b0, trip: 1'b0,
    key_run: 1'b0, key_stop: 1'b0, key_jog: 1'b0, key_dir: 1'b0};

endpackage

/* File: test/dss_pins_model.sv */
// Partner model: keypad keys and terminal switches.
// Assumes the bench sets req_i just after rising edges.
`timescale 1ns/1ps
`default_nettype none
module dss_pins_model
  import dss_pkg::*;
#(
  parameter int unsigned MIN_LOW = 8  // Least halt_n low time
) (
  input wire logic mclk_i,
  input wire dss_pins_t req_i,
  output var dss_pins_t pins_o
);
  int unsigned low_cnt = 0;  // Cycles halt_n held low
  dss_pins_t nxt_pins;       // Levels shown after this edge
  initial pins_o = PIN_RST;
  // Switches follow requests one cycle late; a halt_n tap is
  // stretched so a bounce never reads as a stop too short
  always @(posedge mclk_i)
  begin
    nxt_pins = req_i;
    if (!req_i.halt_n || (low_cnt != 0 && low_cnt < MIN_LOW + 2))
    begin
      nxt_pins.halt_n = 1'b0;
      low_cnt <= low_cnt + 1;
    end
    else
      low_cnt <= 0;
    pins_o <= nxt_pins;
  end
endmodule // dss_pins_model
`default_nettype wire

/* File: test/dss_sequencer_tb.sv */
// Bench for the start/stop sequencer: APB set-up, pin scenarios.
// Assumes the partner model drives the pins; one 125 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module dss_sequencer_tb;
  import dss_pkg::*;
  // ****
  // Signals
  // ****
  localparam dss_pins_t PIN_ON = dss_pins_t'(PIN_RST | 12'h020); // Permit high
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [AW-1:0] padr = '0;
  logic [31:0] pwd = '0;
  logic [31:0] rd, prdata;
  logic err, pready, pslverr, dir, pwr_en, motion, nofault;
  logic [15:0] vel, ofs;
  dss_pins_t req = PIN_RST;  // Switch levels asked of the partner
  dss_pins_t pins;
  int fail_count = 0;
  int compares = 0;
  int cyc = 0;
  int ref_v, inch_v, kp_v;  // Model targets
  always #4 mclk_i = ~mclk_i;
  dss_pins_model #(.MIN_LOW(8)) pm_u (.mclk_i(mclk_i), .req_i(req), .pins_o(pins));
  dss_sequencer #(.HALT_MIN_CYC(8)) dut_u (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(padr), .pwdata_i(pwd),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .pins_i(pins),
    .velocity_command_o(vel), .velocity_offset_o(ofs), .direction_request_out_o(dir),
    .power_stage_en_o(pwr_en), .in_motion_flag_o(motion), .no_fault_flag_o(nofault));
  // ****
  // Tasks
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer; holds until pready seen at an edge
  task automatic apb(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge mclk_i);
    pen <= 1'b1;
    do @(posedge mclk_i); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // Bounded wait for the demand to reach a value
  task automatic wait_for(input int v);
    int n;
    n = 0;
    while (vel !== 16'(v) && n < 300)
    begin
      @(posedge mclk_i);
      n++;
    end
  endtask
  // Partner flop, sync and state latency
  task automatic settle;
    repeat (6) @(posedge mclk_i);
  endtask
  task automatic print_verdict;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Hang guard, far above the expected run length
  always @(posedge mclk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      fail_count++;
      print_verdict;
    end
  end
  // ****
  // Scenarios
  // ****
  initial
  begin
    void'($urandom(32'h1de0));
    ref_v = 8 + int'($urandom % 32);
    inch_v = 4 + int'($urandom % 16);
    kp_v = 6 + int'($urandom % 16);
    repeat (12) @(posedge mclk_i);
    rstn_i <= 1'b1;
    req <= PIN_ON;
    apb(1'b0, OFS_CTRL, '0);
    chk(rd, 32'(CTRL_RST));
    apb(1'b0, OFS_HALT, '0);
    chk(rd, HALT_DEF_STEP);
    apb(1'b0, 8'h30, '0);
    chk(err, 1'b1);
    chk(nofault, 1'b1);
    apb(1'b1, OFS_REF, ref_v);
    apb(1'b1, OFS_INCH, inch_v);
    apb(1'b1, OFS_KPTGT, kp_v);
    apb(1'b1, OFS_RISE, 32'h1);
    apb(1'b1, OFS_FALL, 32'h1);
    apb(1'b1, OFS_IRISE, 32'h1);
    apb(1'b1, OFS_SHOLD, 32'h10);
    // Remote run; jog ignored while running
    req.run <= 1'b1;
    wait_for(ref_v);
    chk(vel, ref_v);
    chk(motion, 1'b1);
    req.jog <= 1'b1;
    settle;
    chk(vel, ref_v);
    req <= PIN_ON;
    wait_for(0);
    chk(vel, 0);
    chk(pwr_en, 1'b1);
    repeat (24) @(posedge mclk_i);
    chk(pwr_en, 1'b0);
    chk(motion, 1'b0);
    // Remote jog; run ignored while jogging
    req.jog <= 1'b1;
    wait_for(inch_v);
    chk(vel, inch_v);
    req.run <= 1'b1;
    settle;
    chk(vel, inch_v);
    req <= PIN_ON;
    wait_for(0);
    chk(vel, 0);
    repeat (24) @(posedge mclk_i);
    // Two-wire: reverse, then both pressed
    apb(1'b1, OFS_CTRL, 32'h43);
    req.reverse <= 1'b1;
    wait_for(ref_v);
    chk(dir, 1'b1);
    req.run <= 1'b1;
    wait_for(0);
    chk(vel, 0);
    req <= PIN_ON;
    repeat (24) @(posedge mclk_i);
    // Three-wire: tap run, then tap halt_n
    apb(1'b1, OFS_CTRL, 32'h83);
    settle;
    chk(motion, 1'b0);
    req.run <= 1'b1;
    settle;
    req.run <= 1'b0;
    wait_for(ref_v);
    chk(vel, ref_v);
    req.halt_n <= 1'b0;
    @(posedge mclk_i);
    req.halt_n <= 1'b1;
    wait_for(0);
    chk(vel, 0);
    repeat (24) @(posedge mclk_i);
    // Keypad run and stop, own then remote reference
    for (int j = 0; j < 2; j++)
    begin
      apb(1'b1, OFS_CTRL, j ? 32'h2 : 32'h0);
      req.key_run <= 1'b1;
      settle;
      req.key_run <= 1'b0;
      wait_for(j ? ref_v : kp_v);
      settle;
      chk(vel, j ? ref_v : kp_v);
      req.key_stop <= 1'b1;
      settle;
      req.key_stop <= 1'b0;
      wait_for(0);
      chk(vel, 0);
      repeat (24) @(posedge mclk_i);
    end
    req.key_jog <= 1'b1;
    wait_for(inch_v);
    chk(vel, inch_v);
    req.key_jog <= 1'b0;
    wait_for(0);
    chk(vel, 0);
    repeat (24) @(posedge mclk_i);
    // Freeze with offset: fall at halt rate, then offset trimmed
    apb(1'b1, OFS_HALT, 32'h2);
    apb(1'b1, OFS_OFFSET, inch_v);
    apb(1'b1, OFS_CTRL, 32'h113);
    req.run <= 1'b1;
    wait_for(ref_v);
    chk(ofs, inch_v);
    req <= PIN_ON;
    wait_for(0);
    chk(ofs, inch_v);
    repeat (2 * inch_v + 8) @(posedge mclk_i);
    chk(ofs, 0);
    chk(pwr_en, 1'b1);
    repeat (24) @(posedge mclk_i);
    chk(pwr_en, 1'b0);
    // Coasting stops, one cause per pass
    apb(1'b1, OFS_CTRL, 32'h0f);
    for (int i = 0; i < 5; i++)
    begin
      req.run <= 1'b1;
      wait_for(ref_v);
      case (i)
        0: req.run <= 1'b0;
        1: req.quick_halt_n <= 1'b0;
        2: req.freewheel_halt_n <= 1'b0;
        3: req.power_stage_enable <= 1'b0;
        default: req.trip <= 1'b1;
      endcase
      settle;
      chk(vel, 0);
      chk(pwr_en, 1'b0);
      chk(nofault, i != 4);
      req <= PIN_ON;
      repeat (24) @(posedge mclk_i);
    end
    // Trip gone but not reset: no restart
    req.run <= 1'b1;
    settle;
    chk(pwr_en, 1'b0);
    apb(1'b1, OFS_CTRL, 32'h2f);
    wait_for(ref_v);
    chk(pwr_en, 1'b1);
    print_verdict;
  end
endmodule // dss_sequencer_tb
`default_nettype wire
